/* File: pkg/frp_consts.svh */
// constants of the flash resume, power-down and identification command set
// assumes a 40 MHz system clock and a host serial clock of 200 ns
`ifndef FRP_CONSTS_SVH
`define FRP_CONSTS_SVH

`define FRP_OP_RESUME 8'h7A
`define FRP_OP_SUSPEND 8'h75
`define FRP_OP_PWRDN 8'hB9
`define FRP_OP_RELEASE 8'hAB
`define FRP_OP_MFR_ID 8'h90
`define FRP_OP_MFR_ID2 8'h92
`define FRP_OP_MFR_ID4 8'h94
`define FRP_OP_UNIQUE 8'h4B
`define FRP_OP_STATUS 8'h05

`define FRP_OPC_BITS 8
`define FRP_ADDR3_BITS 24
`define FRP_ADDR4_BITS 32
`define FRP_MODE_BITS 8
`define FRP_QIO_DUMMY_CLK 4
`define FRP_UID_DUMMY_BITS 32

`define FRP_SR_BUSY 0
`define FRP_SR_WEL 1
`define FRP_SR_SUS 7

`define FRP_CLK_MHZ 40
`define FRP_T_RESUME_NS 200
`define FRP_T_PD_ENTRY_NS 3000
`define FRP_T_PD_RELEASE_NS 3000
`define FRP_T_SUSPEND_NS 20000
`define FRP_T_SCLK_NS 200
// device limits are longest times: round down
`define FRP_RESUME_CYC ((`FRP_T_RESUME_NS * `FRP_CLK_MHZ) / 1000)
`define FRP_PD_ENTRY_CYC ((`FRP_T_PD_ENTRY_NS * `FRP_CLK_MHZ) / 1000)
`define FRP_PD_RELEASE_CYC ((`FRP_T_PD_RELEASE_NS * `FRP_CLK_MHZ) / 1000)
`define FRP_SUSPEND_CYC ((`FRP_T_SUSPEND_NS * `FRP_CLK_MHZ) / 1000)
// host waits are least times: round up
`define FRP_H_RELEASE_CYC ((`FRP_T_PD_RELEASE_NS * `FRP_CLK_MHZ + 999) / 1000)
`define FRP_H_SUSPEND_CYC ((`FRP_T_SUSPEND_NS * `FRP_CLK_MHZ + 999) / 1000)
`define FRP_SCLK_HALF_CYC ((`FRP_T_SCLK_NS * `FRP_CLK_MHZ) / 2000)
`define FRP_CS_GAP_CYC 8
`define FRP_OP_LEN_CYC 4000

`endif

/* File: pkg/frp_pkg.sv */
// types and opcode decoding shared by both ends of the flash link
// assumes frp_consts.svh is on the include path
`default_nettype none
`include "frp_consts.svh"

package frp_pkg;

    typedef enum logic [2:0] {FRP_D_IDLE, FRP_D_OPC, FRP_D_SKIP, FRP_D_OUT, FRP_D_END,
                              FRP_D_IGN} frp_dev_st_t;
    typedef enum logic [2:0] {FRP_P_NONE, FRP_P_SUS, FRP_P_RES, FRP_P_PD,
                              FRP_P_REL} frp_pend_t;
    typedef enum logic [1:0] {FRP_H_IDLE, FRP_H_PRE, FRP_H_RUN, FRP_H_GAP} frp_host_st_t;

    // clocks between the opcode and the first output clock
    function automatic logic [5:0] frp_skip_clks(input logic [7:0] op, input logic quad,
                                                 input logic addr4);
        logic [5:0] a;
        a = addr4 ? 6'(`FRP_ADDR4_BITS) : 6'(`FRP_ADDR3_BITS);
        case (op)
            `FRP_OP_RELEASE: frp_skip_clks = quad ? 6'(`FRP_ADDR3_BITS / 4)
                                                  : 6'(`FRP_ADDR3_BITS);
            `FRP_OP_MFR_ID: frp_skip_clks = 6'(`FRP_ADDR3_BITS);
            `FRP_OP_MFR_ID2: frp_skip_clks = 6'((a + 6'(`FRP_MODE_BITS)) >> 1);
            `FRP_OP_MFR_ID4: frp_skip_clks = 6'(`FRP_QIO_DUMMY_CLK)
                                             + 6'((a + 6'(`FRP_MODE_BITS)) >> 2);
            `FRP_OP_UNIQUE: frp_skip_clks = 6'(`FRP_UID_DUMMY_BITS);
            default: frp_skip_clks = 6'h00;
        endcase
    endfunction : frp_skip_clks

    // bits per clock after the opcode
    function automatic logic [2:0] frp_width(input logic [7:0] op, input logic quad);
        if (quad || op == `FRP_OP_MFR_ID4)
            frp_width = 3'h4;
        else if (op == `FRP_OP_MFR_ID2)
            frp_width = 3'h2;
        else
            frp_width = 3'h1;
    endfunction : frp_width

    // opcodes that answer with data; the identification reads exist in serial mode only
    function automatic logic frp_is_read(input logic [7:0] op, input logic quad);
        frp_is_read = (op == `FRP_OP_RELEASE) || (op == `FRP_OP_STATUS)
                      || (!quad && (op == `FRP_OP_MFR_ID || op == `FRP_OP_MFR_ID2
                                    || op == `FRP_OP_MFR_ID4 || op == `FRP_OP_UNIQUE));
    endfunction : frp_is_read

endpackage : frp_pkg

`default_nettype wire

/* File: pkg/frp_link_if.sv */
// serial flash link: chip select, serial clock and four data lines
// assumes a weak pull-up on each data line; the wire level is resolved here
`default_nettype none

interface frp_link_if;
    logic cs_b;
    logic sclk;
    logic [3:0] h_io;
    logic [3:0] h_oe;
    logic [3:0] d_io;
    logic [3:0] d_oe;
    wire [3:0] io_lvl;

    assign io_lvl = (d_io & d_oe) | (h_io & h_oe) | ~(d_oe | h_oe);

    modport dev (input cs_b, input sclk, input io_lvl, output d_io, output d_oe);
    modport host (output cs_b, output sclk, output h_io, output h_oe, input io_lvl);
endinterface : frp_link_if

`default_nettype wire

/* File: hw/frp_flash_dev.sv */
// flash device end: resume, suspend, power-down, release and identification reads
// assumes link pins asynchronous to CLOCK; user-side inputs are on CLOCK
// Contract
// - resume taken only when suspended and idle
// - resume clears suspend, busy returns within 200ns
// - resume otherwise ignored, state untouched
// - power failure drops suspended state, resume ignored
// - host waits suspend time before next suspend
// - power-down byte needs select raised after bit eight
// - power-down entered within entry time
// - powered down: only release opcode recognised
// - power-on always in normal state
// - power-down discards volatile status bits; here only the write latch clears, suspend stays set
// - release opcode alone, select high release time
// - release plus three dummies repeats device ID
// - ID read: zero address, maker then device
// - dual ID read: two bits per clock
// - quad ID read: dummies, address, four bits
// - host drives mode bits upper nibble ones
// - four-byte mode lengthens address to 32
// - unique read: four dummy bytes, 64 bits
// - suspend only while running and not suspended
`default_nettype none
`include "frp_consts.svh"

module frp_flash_dev
    import frp_pkg::*;
#(
    parameter logic [7:0] MFR_ID = 8'h5A, // arbitrary value
    parameter logic [7:0] DEV_ID = 8'h19, // arbitrary value
    parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF // arbitrary value
)(
    input wire logic CLOCK,
    input wire logic RST_B,
    frp_link_if.dev LINK,
    input wire logic QUAD_MODE,
    input wire logic ADDR4_MODE,
    input wire logic OP_START,
    input wire logic OP_SUSPENDABLE,
    input wire logic POWER_FAIL,
    input wire logic WEL_SET,
    output logic BUSY,
    output logic SUSPENDED,
    output logic POWERED_DOWN,
    output logic WEL
);

    logic [1:0] cs_sync_r;
    logic [1:0] ck_sync_r;
    logic [3:0] io_meta_r;
    logic [3:0] io_sync_r;
    logic cs_last_r;
    logic ck_last_r;
    frp_dev_st_t st_r, st_nxt;
    logic [5:0] cnt_r, cnt_nxt;
    logic [7:0] opc_r, opc_nxt;
    logic [63:0] pat_r, pat_nxt;
    logic [2:0] w_r, w_nxt;
    logic [3:0] dout_r;
    logic [3:0] doe_r;
    frp_pend_t pend_r;
    logic [11:0] tmr_r;
    logic busy_r;
    logic sus_r;
    logic pd_r;
    logic wel_r;
    logic susp_ok_r;
    logic [11:0] op_left_r;

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            cs_sync_r <= 2'h3;
            ck_sync_r <= 2'h0;
            io_meta_r <= 4'hF;
            io_sync_r <= 4'hF;
            cs_last_r <= 1'h1;
            ck_last_r <= 1'h0;
        end
        else
        begin
            cs_sync_r <= {cs_sync_r[0], LINK.cs_b};
            ck_sync_r <= {ck_sync_r[0], LINK.sclk};
            io_meta_r <= LINK.io_lvl;
            io_sync_r <= io_meta_r;
            cs_last_r <= cs_sync_r[1];
            ck_last_r <= ck_sync_r[1];
        end
    end

    wire cs_low = ~cs_sync_r[1];
    wire cs_rise = cs_sync_r[1] & ~cs_last_r;
    wire ck_rise = ck_sync_r[1] & ~ck_last_r;
    wire ck_fall = ~ck_sync_r[1] & ck_last_r;

    // opcode shift-in, one or four bits per rising clock
    wire [2:0] in_w = QUAD_MODE ? 3'h4 : 3'h1;
    wire [5:0] cnt_inc = cnt_r + {3'h0, in_w};
    wire [7:0] opc_shift = QUAD_MODE ? {opc_r[3:0], io_sync_r} : {opc_r[6:0], io_sync_r[0]};
    wire opc_done = (cnt_inc == 6'(`FRP_OPC_BITS));
    wire pd_like = pd_r | (pend_r == FRP_P_PD);
    wire [5:0] skip = frp_skip_clks(opc_shift, QUAD_MODE, ADDR4_MODE);
    wire is_cs_op = (opc_shift == `FRP_OP_RESUME) || (opc_shift == `FRP_OP_SUSPEND)
                    || (opc_shift == `FRP_OP_PWRDN);
    wire is_exec = pd_like ? (opc_shift == `FRP_OP_RELEASE) : is_cs_op;
    wire is_read = frp_is_read(opc_shift, QUAD_MODE) & ~pd_like;

    wire [7:0] status = 8'({sus_r, 7'h00} >> (7 - `FRP_SR_SUS))
                        | 8'({wel_r, 1'h0} >> (1 - `FRP_SR_WEL))
                        | 8'({busy_r} << `FRP_SR_BUSY);

    // answer patterns repeat inside 64 bits so a plain rotation loops them
    wire [63:0] pat_load = (opc_shift == `FRP_OP_RELEASE) ? {8{DEV_ID}}
                         : (opc_shift == `FRP_OP_STATUS) ? {8{status}}
                         : (opc_shift == `FRP_OP_UNIQUE) ? UNIQUE_ID
                         : {4{MFR_ID, DEV_ID}};
    wire w4 = (w_r == 3'h4);
    wire w2 = (w_r == 3'h2);
    wire [63:0] pat_rot = w4 ? {pat_r[59:0], pat_r[63:60]}
                        : w2 ? {pat_r[61:0], pat_r[63:62]}
                        : {pat_r[62:0], pat_r[63]};
    wire [3:0] out_bits = w4 ? pat_r[63:60]
                        : w2 ? {2'h0, pat_r[63:62]}
                        : {2'h0, pat_r[63], 1'h0};
    wire [3:0] out_en = w4 ? 4'hF : w2 ? 4'h3 : 4'h2;

    always_comb
    begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        opc_nxt = opc_r;
        pat_nxt = pat_r;
        w_nxt = w_r;
        if (!cs_low)
        begin
            st_nxt = FRP_D_IDLE;
            cnt_nxt = 6'h00;
        end
        else
        begin
            unique case (st_r)
                FRP_D_IDLE:
                begin
                    st_nxt = FRP_D_OPC;
                    cnt_nxt = 6'h00;
                end
                FRP_D_OPC:
                    if (ck_rise)
                    begin
                        opc_nxt = opc_shift;
                        cnt_nxt = cnt_inc;
                        if (opc_done && is_exec)
                            st_nxt = FRP_D_END;
                        else if (opc_done && is_read)
                        begin
                            pat_nxt = pat_load;
                            w_nxt = frp_width(opc_shift, QUAD_MODE);
                            cnt_nxt = skip;
                            st_nxt = (skip == 6'h00) ? FRP_D_OUT : FRP_D_SKIP;
                        end
                        else if (opc_done)
                            st_nxt = FRP_D_IGN;
                    end
                FRP_D_SKIP:
                    if (ck_rise)
                    begin
                        cnt_nxt = cnt_r - 6'h01;
                        if (cnt_r == 6'h01)
                            st_nxt = FRP_D_OUT;
                    end
                FRP_D_OUT:
                    if (ck_fall)
                        pat_nxt = pat_rot;
                FRP_D_END:
                    if (ck_rise)
                        st_nxt = FRP_D_IGN;
                FRP_D_IGN:
                    st_nxt = FRP_D_IGN;
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            st_r <= FRP_D_IDLE;
            cnt_r <= 6'h00;
            opc_r <= 8'h00;
            pat_r <= 64'h0;
            w_r <= 3'h1;
        end
        else
        begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            opc_r <= opc_nxt;
            pat_r <= pat_nxt;
            w_r <= w_nxt;
        end
    end

    // data leaves on falling serial clock edges, most significant first
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            dout_r <= 4'h0;
            doe_r <= 4'h0;
        end
        else if (!cs_low || st_r != FRP_D_OUT)
            doe_r <= 4'h0;
        else if (ck_fall)
        begin
            dout_r <= out_bits;
            doe_r <= out_en;
        end
    end

    assign LINK.d_io = dout_r;
    assign LINK.d_oe = doe_r;

    // commands that act on the rise of select after exactly eight bits
    wire exec = cs_rise & (st_r == FRP_D_END);
    wire idle_pend = (pend_r == FRP_P_NONE);
    wire do_resume = exec & (opc_r == `FRP_OP_RESUME) & sus_r & ~busy_r & idle_pend;
    wire do_suspend = exec & (opc_r == `FRP_OP_SUSPEND) & busy_r & susp_ok_r & ~sus_r
                      & idle_pend;
    wire do_pd = exec & (opc_r == `FRP_OP_PWRDN) & ~pd_like & ~busy_r & idle_pend;
    wire do_rel = exec & (opc_r == `FRP_OP_RELEASE) & pd_r & idle_pend;
    wire tmr_done = ~idle_pend & (tmr_r == 12'h000);
    wire start_op = OP_START & ~busy_r & ~sus_r & ~pd_like & idle_pend;
    wire op_run = busy_r & (pend_r != FRP_P_SUS);
    wire op_end = op_run & (op_left_r == 12'h001);

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            pend_r <= FRP_P_NONE;
            tmr_r <= 12'h000;
        end
        else if (POWER_FAIL)
            pend_r <= FRP_P_NONE;
        else if (do_resume)
        begin
            pend_r <= FRP_P_RES;
            tmr_r <= 12'(`FRP_RESUME_CYC - 1);
        end
        else if (do_suspend)
        begin
            pend_r <= FRP_P_SUS;
            tmr_r <= 12'(`FRP_SUSPEND_CYC - 1);
        end
        else if (do_pd)
        begin
            pend_r <= FRP_P_PD;
            tmr_r <= 12'(`FRP_PD_ENTRY_CYC - 1);
        end
        else if (do_rel)
        begin
            pend_r <= FRP_P_REL;
            tmr_r <= 12'(`FRP_PD_RELEASE_CYC - 1);
        end
        else if (tmr_done)
            pend_r <= FRP_P_NONE;
        else if (!idle_pend)
            tmr_r <= tmr_r - 12'h001;
    end

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
            sus_r <= 1'h0;
        else if (POWER_FAIL)
            sus_r <= 1'h0;
        else if (do_resume)
            sus_r <= 1'h0;
        else if (do_suspend)
            sus_r <= 1'h1;
    end

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
            busy_r <= 1'h0;
        else if (POWER_FAIL)
            busy_r <= 1'h0;
        else if (start_op || (tmr_done && pend_r == FRP_P_RES))
            busy_r <= 1'h1;
        else if (op_end || (tmr_done && pend_r == FRP_P_SUS))
            busy_r <= 1'h0;
    end

    // the suspended operation keeps its remaining length and finishes after resume
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            op_left_r <= 12'h000;
            susp_ok_r <= 1'h0;
        end
        else if (start_op)
        begin
            op_left_r <= 12'(`FRP_OP_LEN_CYC);
            susp_ok_r <= OP_SUSPENDABLE;
        end
        else if (op_run)
            op_left_r <= op_left_r - 12'h001;
    end

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
            pd_r <= 1'h0;
        else if (POWER_FAIL)
            pd_r <= 1'h0;
        else if (tmr_done && pend_r == FRP_P_PD)
            pd_r <= 1'h1;
        else if (tmr_done && pend_r == FRP_P_REL)
            pd_r <= 1'h0;
    end

    // power loss and power-down entry always discard the latch; a set beats the end-of-op clear
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
            wel_r <= 1'h0;
        else if (POWER_FAIL || do_pd)
            wel_r <= 1'h0;
        else if (WEL_SET && !pd_like)
            wel_r <= 1'h1;
        else if (op_end)
            wel_r <= 1'h0;
    end

    assign BUSY = busy_r;
    assign SUSPENDED = sus_r;
    assign POWERED_DOWN = pd_r;
    assign WEL = wel_r;

endmodule : frp_flash_dev

`default_nettype wire

/* File: hw/frp_flash_host.sv */
// flash host end: issues one command per request and returns the read bits
// assumes the link device samples on rising and drives on falling serial clock
`default_nettype none
`include "frp_consts.svh"

module frp_flash_host
    import frp_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST_B,
    frp_link_if.host LINK,
    input wire logic QUAD_MODE,
    input wire logic ADDR4_MODE,
    input wire logic CMD_VALID,
    output logic CMD_READY,
    input wire logic [7:0] CMD_OP,
    input wire logic [6:0] CMD_RD_CLKS,
    output logic RSP_VALID,
    output logic [63:0] RSP_DATA
);

    frp_host_st_t st_r;
    logic [2:0] div_r;
    logic sclk_r;
    logic cs_b_r;
    logic [7:0] op_r;
    logic [6:0] rd_r;
    logic [7:0] idx_r;
    logic [7:0] tot_r;
    logic [3:0] ho_r;
    logic [3:0] hoe_r;
    logic [63:0] rx_r;
    logic rsp_r;
    logic [11:0] gap_r;
    logic [11:0] tsus_r;
    logic [3:0] io_meta_r;
    logic [3:0] io_sync_r;

    wire tick = (div_r == 3'h0);
    wire [7:0] ocl = QUAD_MODE ? 8'h02 : 8'(`FRP_OPC_BITS);
    wire release_only = (CMD_OP == `FRP_OP_RELEASE) && (CMD_RD_CLKS == 7'h00);
    wire [7:0] tot_new = release_only ? ocl
                         : ocl + {2'h0, frp_skip_clks(CMD_OP, QUAD_MODE, ADDR4_MODE)};
    wire [7:0] end_idx = tot_r + {1'h0, rd_r};
    wire [2:0] w = frp_width(op_r, QUAD_MODE);
    wire [3:0] w_mask = (w == 3'h4) ? 4'hF : (w == 3'h2) ? 4'h3 : 4'h1;

    // bits for the clock numbered idx_r
    wire in_opc = (idx_r < ocl);
    wire [3:0] opc_bits = QUAD_MODE ? ((idx_r == 8'h00) ? op_r[7:4] : op_r[3:0])
                                    : {3'h0, op_r[3'(7 - idx_r)]};
    wire [7:0] rem = tot_r - idx_r;
    wire [7:0] mclk = (w == 3'h4) ? 8'(`FRP_MODE_BITS / 4) : 8'(`FRP_MODE_BITS / 2);
    wire io_id = (op_r == `FRP_OP_MFR_ID2) || (op_r == `FRP_OP_MFR_ID4);
    wire mode_hi = io_id && (rem <= mclk) && (rem > (mclk >> 1));
    wire [3:0] drv = in_opc ? opc_bits : (mode_hi ? w_mask : 4'h0);
    wire [3:0] drv_oe = in_opc ? (QUAD_MODE ? 4'hF : 4'h1) : w_mask;
    wire [63:0] rx_in = (w == 3'h4) ? {rx_r[59:0], io_sync_r}
                      : (w == 3'h2) ? {rx_r[61:0], io_sync_r[1:0]}
                      : {rx_r[62:0], io_sync_r[1]};

    assign CMD_READY = (st_r == FRP_H_IDLE)
                       && !((CMD_OP == `FRP_OP_SUSPEND) && (tsus_r != 12'h000));

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            io_meta_r <= 4'hF;
            io_sync_r <= 4'hF;
            div_r <= 3'h0;
        end
        else
        begin
            io_meta_r <= LINK.io_lvl;
            io_sync_r <= io_meta_r;
            div_r <= tick ? 3'(`FRP_SCLK_HALF_CYC - 1) : div_r - 3'h1;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            st_r <= FRP_H_IDLE;
            sclk_r <= 1'h0;
            cs_b_r <= 1'h1;
            op_r <= 8'h00;
            rd_r <= 7'h00;
            idx_r <= 8'h00;
            tot_r <= 8'h00;
            ho_r <= 4'h0;
            hoe_r <= 4'h0;
            rx_r <= 64'h0;
            rsp_r <= 1'h0;
            gap_r <= 12'h000;
        end
        else
        begin
            rsp_r <= 1'h0;
            unique case (st_r)
                FRP_H_IDLE:
                    if (CMD_VALID && CMD_READY)
                    begin
                        op_r <= CMD_OP;
                        rd_r <= CMD_RD_CLKS;
                        tot_r <= tot_new;
                        idx_r <= 8'h00;
                        rx_r <= 64'h0;
                        cs_b_r <= 1'h0;
                        st_r <= FRP_H_PRE;
                    end
                FRP_H_PRE:
                    if (tick)
                    begin
                        ho_r <= drv;
                        hoe_r <= drv_oe;
                        st_r <= FRP_H_RUN;
                    end
                FRP_H_RUN:
                    if (tick && !sclk_r)
                    begin
                        sclk_r <= 1'h1;
                        idx_r <= idx_r + 8'h01;
                    end
                    else if (tick)
                    begin
                        sclk_r <= 1'h0;
                        if (idx_r > tot_r)
                            rx_r <= rx_in;
                        if (idx_r == end_idx)
                        begin
                            cs_b_r <= 1'h1;
                            hoe_r <= 4'h0;
                            rsp_r <= (rd_r != 7'h00);
                            gap_r <= (op_r == `FRP_OP_RELEASE && rd_r == 7'h00)
                                     ? 12'(`FRP_H_RELEASE_CYC) : 12'(`FRP_CS_GAP_CYC);
                            st_r <= FRP_H_GAP;
                        end
                        else if (idx_r >= tot_r)
                            hoe_r <= 4'h0;
                        else
                        begin
                            ho_r <= drv;
                            hoe_r <= drv_oe;
                        end
                    end
                FRP_H_GAP:
                    if (gap_r == 12'h000)
                        st_r <= FRP_H_IDLE;
                    else
                        gap_r <= gap_r - 12'h001;
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
            tsus_r <= 12'h000;
        else if (rsp_r == 1'h0 && st_r == FRP_H_RUN && cs_b_r == 1'h0
                 && op_r == `FRP_OP_RESUME)
            tsus_r <= 12'(`FRP_H_SUSPEND_CYC);
        else if (tsus_r != 12'h000)
            tsus_r <= tsus_r - 12'h001;
    end

    assign LINK.cs_b = cs_b_r;
    assign LINK.sclk = sclk_r;
    assign LINK.h_io = ho_r;
    assign LINK.h_oe = hoe_r;
    assign RSP_VALID = rsp_r;
    assign RSP_DATA = rx_r;

endmodule : frp_flash_host

`default_nettype wire

/* File: testbench/frp_chk_sva.sv */
// checker of link and device status relations
// assumes one CLOCK domain, reset active low
`default_nettype none
module frp_chk (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic cs_b,
    input wire logic [3:0] d_oe,
    input wire logic POWER_FAIL,
    input wire logic BUSY,
    input wire logic SUSPENDED,
    input wire logic POWERED_DOWN,
    input wire logic WEL
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_B);
    sequence s_resumed;
        $fell(SUSPENDED) && !$past(POWER_FAIL);
    endsequence
    sequence s_busy_back;
        ##[1:8] BUSY;
    endsequence
    AST_RES_BUSY: assert property (s_resumed |-> s_busy_back)
        else $error("busy late after resume");
    AST_RES_IDLE: assert property (s_resumed |-> !$past(BUSY))
        else $error("resume taken while busy");
    AST_SUS_BUSY: assert property ($rose(SUSPENDED) |-> ##[1:800] !BUSY)
        else $error("suspend left busy");
    AST_PD_CS: assert property ($rose(POWERED_DOWN) |-> cs_b)
        else $error("power-down inside a frame");
    AST_PD_WEL: assert property (POWERED_DOWN |-> !WEL)
        else $error("write latch kept in power-down");
    AST_PD_MUTE: assert property (POWERED_DOWN && $past(POWERED_DOWN) |-> d_oe == 4'h0)
        else $error("device drives in power-down");
    AST_OE_OFF: assert property ($rose(cs_b) |-> ##4 d_oe == 4'h0)
        else $error("device drives after frame");
    AST_PON: assert property ($rose(RST_B) |-> !POWERED_DOWN)
        else $error("powered down after reset");
endmodule : frp_chk
`default_nettype wire

/* File: testbench/flash_resume_powerdown_id_cmds_bench.sv */
// bench: both link ends joined, commands driven at the host end
// assumes the IDs below
`default_nettype none
module flash_resume_powerdown_id_cmds_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] MFR = 8'h5A; // arbitrary value
    localparam logic [7:0] DEV = 8'h19; // arbitrary value
    localparam logic [63:0] UID = 64'h0123_4567_89AB_CDEF; // arbitrary value
    localparam logic [63:0] MD = {4{MFR, DEV}};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic a4 = 1'b0;
    logic q = 1'b0;
    logic sok = 1'b1;
    logic vld = 1'b0;
    logic [2:0] pls = 3'h0;
    logic [7:0] op = 8'h00;
    logic [6:0] n = 7'h00;
    logic rdy, rv, busy, suspend_flag, pd, wel;
    logic [63:0] rd, got, st;
    int errors = 0;
    int checks = 0;
    int cyc = 0;
    assign st = {60'h0, pd, wel, suspend_flag, busy};
    frp_link_if lnk ();
    frp_flash_dev #(.MFR_ID(MFR), .DEV_ID(DEV), .UNIQUE_ID(UID)) frp_flash_dev_i (
        .CLOCK(clk), .RST_B(rst_b), .LINK(lnk), .QUAD_MODE(q), .ADDR4_MODE(a4),
        .OP_START(pls[0]), .OP_SUSPENDABLE(sok), .POWER_FAIL(pls[1]), .WEL_SET(pls[2]),
        .BUSY(busy), .SUSPENDED(suspend_flag), .POWERED_DOWN(pd), .WEL(wel));
    frp_flash_host frp_flash_host_i (.CLOCK(clk), .RST_B(rst_b), .LINK(lnk), .QUAD_MODE(q),
        .ADDR4_MODE(a4), .CMD_VALID(vld), .CMD_READY(rdy), .CMD_OP(op), .CMD_RD_CLKS(n),
        .RSP_VALID(rv), .RSP_DATA(rd));
    frp_chk frp_chk_i (.CLOCK(clk), .RST_B(rst_b), .cs_b(lnk.cs_b), .d_oe(lnk.d_oe),
        .POWER_FAIL(pls[1]), .BUSY(busy), .SUSPENDED(suspend_flag), .POWERED_DOWN(pd), .WEL(wel));
    task automatic chk(input string s, input logic [63:0] e, input logic [63:0] g);
        checks++;
        if (g !== e)
        begin
            errors++;
            $display("BAD %s exp %h got %h", s, e, g);
        end
    endtask : chk
    task automatic send(input logic [7:0] o, input logic [6:0] k);
        @(posedge clk);
        op <= o;
        n <= k;
        vld <= 1'b1;
        do @(posedge clk); while (!rdy);
        vld <= 1'b0;
        @(negedge clk);
        while (k != 7'h00 ? !rv : !rdy) @(negedge clk);
        got = rd;
    endtask : send
    task automatic step(input string s, input logic [7:0] o, input logic [6:0] k,
                        input int w, input logic [3:0] e);
        send(o, k);
        repeat (w) @(posedge clk);
        chk(s, {60'h0, e}, st);
    endtask : step
    task automatic pulse(input logic [2:0] v);
        @(posedge clk);
        pls <= v;
        @(posedge clk);
        pls <= 3'h0;
    endtask : pulse
    task automatic t_ids();
        send(8'hAB, 7'h10);
        chk("ab", {48'h0, DEV, DEV}, got);
        send(8'h90, 7'h10);
        chk("90", {48'h0, MFR, DEV}, got);
        for (int a = 0; a < 2; a++)
        begin
            @(posedge clk);
            a4 <= 1'(a);
            send(8'h92, 7'h10);
            chk("92", {32'h0, MD[31:0]}, got);
            send(8'h94, 7'h10);
            chk("94", MD, got);
        end
        send(8'h4B, 7'h40);
        chk("4b", UID, got);
        @(posedge clk);
        q <= 1'b1;
        send(8'hAB, 7'h04);
        chk("ab quad", {48'h0, DEV, DEV}, got);
        @(posedge clk);
        q <= 1'b0;
        $display("ids done");
    endtask : t_ids
    task automatic t_res();
        pulse(3'h1);
        step("7a busy", 8'h7A, 7'h00, 12, 4'h1);
        step("75", 8'h75, 7'h00, 12, 4'h3);
        repeat (810) @(posedge clk);
        chk("75 idle", 64'h2, st);
        step("7a", 8'h7A, 7'h00, 12, 4'h1);
        op <= 8'h75;
        @(negedge clk);
        chk("75 held", 64'h0, {63'h0, rdy});
        step("75 again", 8'h75, 7'h00, 820, 4'h2);
        pulse(3'h2);
        step("7a lost", 8'h7A, 7'h00, 12, 4'h0);
        sok <= 1'b0;
        pulse(3'h1);
        step("75 chip", 8'h75, 7'h00, 12, 4'h1);
        sok <= 1'b1;
        pulse(3'h2);
        $display("resume done");
    endtask : t_res
    task automatic t_pd();
        pulse(3'h4);
        send(8'h05, 7'h08);
        chk("05", 64'h2, got);
        step("b9 long", 8'hB9, 7'h08, 130, 4'h4);
        step("b9", 8'hB9, 7'h00, 130, 4'h8);
        pulse(3'h4);
        step("90 pd", 8'h90, 7'h10, 0, 4'h8);
        chk("pd data", 64'hFFFF, got);
        send(8'h05, 7'h08);
        chk("05 pd", 64'hFF, got);
        step("ab rel", 8'hAB, 7'h00, 10, 4'h0);
        $display("power-down done");
    endtask : t_pd
    task automatic close_out();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            close_out();
        end
    end
    initial
    begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk("pon", 64'h0, st);
        t_ids();
        t_res();
        t_pd();
        close_out();
    end
endmodule : flash_resume_powerdown_id_cmds_bench
`default_nettype wire
